// ### hdl/trim_swap_pkg.sv
// constants and types shared by the trim and swap-delay register bank
//
// Functional notes
// - input c termination trim: 8-bit read-write, loaded from fuses after reset
// - input d termination trim: 8-bit read-write, loaded from fuses after reset
// - during a swap two cores sample together for 4 + 2*overlap delay cycles
// - overlap delay field bits 4:0, range 0 to 31, reset value 8
// - stream steer delay register, 8 bits at own address, reset value 7
// - steer delay bits 4:0 delays the output select, only during swaps
package trim_swap_pkg;

  // ----------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------
  localparam logic [9:0] IDX_TRIM_C    = 10'h080;
  localparam logic [9:0] IDX_TRIM_D    = 10'h081;
  localparam logic [9:0] IDX_OVERLAP   = 10'h09A;
  localparam logic [9:0] IDX_STEER     = 10'h09B;
  localparam logic [9:0] IDX_CONTROL   = 10'h0A0;
  localparam logic [9:0] IDX_STATUS    = 10'h0A1;

  // ----------------------------------------
  // reset values and fields
  // ----------------------------------------
  localparam logic [7:0] RST_TRIM      = 8'h00;
  localparam logic [7:0] RST_OVERLAP   = 8'h08;
  localparam logic [7:0] RST_STEER     = 8'h07;
  localparam int         DLY_MSB       = 4;
  localparam int         CTL_CAL_EN    = 0;
  localparam int         CTL_SWAP_GO   = 1;
  localparam logic [6:0] OVERLAP_BASE  = 7'h04;

  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic {SW_IDLE, SW_RUN} swap_state_t;

  typedef struct packed {
    logic       fuse_loaded;
    logic       stream_select;
    logic       dual_sample_active;
    logic       swap_busy;
  } status_t;

endpackage

// ### hdl/trim_swap_regs.sv
// axi4-lite register bank for input trims and background swap delays
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module trim_swap_regs
  import trim_swap_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  fuse_trim_c,
  input  wire logic [7:0]  fuse_trim_d,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [7:0]       input_c_termination_trim,
  output logic [7:0]       input_d_termination_trim,
  output logic [7:0]       dual_sample_overlap_delay,
  output logic [7:0]       stream_steer_delay,
  output logic             calibration_enable,
  output logic             dual_sample_active,
  output logic             stream_select
);

  // ----------------------------------------
  // write channel capture
  // ----------------------------------------
  logic        aw_held;
  logic [31:0] aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        fuse_loaded;
  wire         aw_take = s_axi_awvalid && s_axi_awready;
  wire         w_take  = s_axi_wvalid && s_axi_wready;
  wire         commit  = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (commit) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (commit) begin
        w_held <= 1'b0;
      end
    end
  end

  // ready is a flop: dropped the cycle a channel is taken, held off until the
  // response is accepted so at most one write is in flight
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= fuse_loaded && !aw_held && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= fuse_loaded && !w_held && !w_take && !s_axi_bvalid;
    end
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire       wr_upper_ok = (aw_addr[31:12] == 20'h00000) && (aw_addr[1:0] == 2'h0);
  wire [9:0] wr_idx      = aw_addr[11:2];
  wire       lane0       = w_strb[0];
  wire       wr_trim_c   = commit && wr_upper_ok && (wr_idx == IDX_TRIM_C);
  wire       wr_trim_d   = commit && wr_upper_ok && (wr_idx == IDX_TRIM_D);
  wire       wr_overlap  = commit && wr_upper_ok && (wr_idx == IDX_OVERLAP);
  wire       wr_steer    = commit && wr_upper_ok && (wr_idx == IDX_STEER);
  wire       wr_control  = commit && wr_upper_ok && (wr_idx == IDX_CONTROL);
  wire       wr_status   = commit && wr_upper_ok && (wr_idx == IDX_STATUS);
  wire       wr_mapped   = wr_trim_c || wr_trim_d || wr_overlap || wr_steer
                           || wr_control || wr_status;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // trims: fuse copy on the first edge after reset, then software owned
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fuse_loaded              <= 1'b0;
      input_c_termination_trim <= RST_TRIM;
      input_d_termination_trim <= RST_TRIM;
    end else if (!fuse_loaded) begin
      fuse_loaded              <= 1'b1;
      input_c_termination_trim <= fuse_trim_c;
      input_d_termination_trim <= fuse_trim_d;
    end else begin
      if (wr_trim_c && lane0)
        input_c_termination_trim <= w_data[7:0];
      if (wr_trim_d && lane0)
        input_d_termination_trim <= w_data[7:0];
    end
  end

  // reserved bits 7:5 are stored as written; keeping them zero is software's
  // job, and the swap logic only ever looks at bits 4:0
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dual_sample_overlap_delay <= RST_OVERLAP;
      stream_steer_delay        <= RST_STEER;
      calibration_enable        <= 1'b0;
    end else begin
      if (wr_overlap && lane0)
        dual_sample_overlap_delay <= w_data[7:0];
      if (wr_steer && lane0)
        stream_steer_delay <= w_data[7:0];
      if (wr_control && lane0)
        calibration_enable <= w_data[CTL_CAL_EN];
    end
  end

  // ----------------------------------------
  // background swap sequencer
  // ----------------------------------------
  swap_state_t swap_state;
  logic [6:0]  overlap_cnt;
  logic [4:0]  steer_cnt;
  logic        steer_pending;
  wire         swap_go  = wr_control && lane0 && w_data[CTL_SWAP_GO]
                          && w_data[CTL_CAL_EN];
  wire [6:0]   overlap_len = OVERLAP_BASE
                             + {1'b0, dual_sample_overlap_delay[DLY_MSB:0], 1'b0};
  wire         swap_start = (swap_state == SW_IDLE) && swap_go;
  wire         swap_end   = (swap_state == SW_RUN) && !dual_sample_active && !steer_pending;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      swap_state         <= SW_IDLE;
      dual_sample_active <= 1'b0;
      overlap_cnt        <= 7'h00;
      steer_pending      <= 1'b0;
      steer_cnt          <= 5'h00;
      stream_select      <= 1'b0;
    end else begin
      case (swap_state)
        SW_IDLE: begin
          if (swap_start) begin
            swap_state         <= SW_RUN;
            dual_sample_active <= 1'b1;
            overlap_cnt        <= overlap_len - 7'h01;
            steer_pending      <= 1'b1;
            steer_cnt          <= stream_steer_delay[DLY_MSB:0];
          end
        end
        SW_RUN: begin
          if (dual_sample_active) begin
            if (overlap_cnt == 7'h00)
              dual_sample_active <= 1'b0;
            else
              overlap_cnt <= overlap_cnt - 7'h01;
          end
          if (steer_pending) begin
            if (steer_cnt == 5'h00) begin
              steer_pending <= 1'b0;
              stream_select <= !stream_select;
            end else begin
              steer_cnt <= steer_cnt - 5'h01;
            end
          end
          if (swap_end)
            swap_state <= SW_IDLE;
        end
        default: swap_state <= SW_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  status_t   status;
  assign status = '{fuse_loaded:        fuse_loaded,
                    stream_select:      stream_select,
                    dual_sample_active: dual_sample_active,
                    swap_busy:          (swap_state == SW_RUN)};

  wire       rd_upper_ok = (s_axi_araddr[31:12] == 20'h00000)
                           && (s_axi_araddr[1:0] == 2'h0);
  wire [9:0] rd_idx      = s_axi_araddr[11:2];
  wire       ar_take     = s_axi_arvalid && s_axi_arready;
  wire       rd_hit_c    = rd_upper_ok && (rd_idx == IDX_TRIM_C);
  wire       rd_hit_d    = rd_upper_ok && (rd_idx == IDX_TRIM_D);
  wire       rd_hit_ov   = rd_upper_ok && (rd_idx == IDX_OVERLAP);
  wire       rd_hit_st   = rd_upper_ok && (rd_idx == IDX_STEER);
  wire       rd_hit_ctl  = rd_upper_ok && (rd_idx == IDX_CONTROL);
  wire       rd_hit_sts  = rd_upper_ok && (rd_idx == IDX_STATUS);
  wire       rd_mapped   = rd_hit_c || rd_hit_d || rd_hit_ov || rd_hit_st
                           || rd_hit_ctl || rd_hit_sts;
  wire [7:0] rd_byte     = rd_hit_c   ? input_c_termination_trim :
                           rd_hit_d   ? input_d_termination_trim :
                           rd_hit_ov  ? dual_sample_overlap_delay :
                           rd_hit_st  ? stream_steer_delay :
                           rd_hit_ctl ? {7'h00, calibration_enable} :
                           rd_hit_sts ? {4'h0, status} : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= fuse_loaded && !ar_take && !s_axi_rvalid;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // checked one edge after the load: at the release edge the trims still show reset values
  AST_TRIM_C_FUSE: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(fuse_loaded) |-> input_c_termination_trim == $past(fuse_trim_c))
    else $error("trim c not loaded from fuse");

  AST_TRIM_D_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
    (fuse_loaded && wr_trim_d && lane0) |=> input_d_termination_trim == $past(w_data[7:0]))
    else $error("trim d write lost");

  AST_OVERLAP_LEN: assert property (@(posedge clk) disable iff (!reset_n)
    swap_start |=> dual_sample_active [*4])
    else $error("overlap shorter than four cycles");

  AST_OVERLAP_END: assert property (@(posedge clk) disable iff (!reset_n)
    (dual_sample_active && overlap_cnt == 7'h00) |=> !dual_sample_active)
    else $error("overlap ran past its count");

  AST_OVERLAP_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
    swap_start |=> overlap_cnt == 7'(4 + 2 * $past(dual_sample_overlap_delay[4:0]) - 1))
    else $error("overlap count wrong");

  AST_OVERLAP_RST: assert property (@(posedge clk)
    $rose(reset_n) |-> dual_sample_overlap_delay == 8'h08)
    else $error("overlap delay reset value wrong");

  AST_STEER_RST: assert property (@(posedge clk)
    $rose(reset_n) |-> stream_steer_delay == 8'h07)
    else $error("steer delay reset value wrong");

  AST_STEER_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
    (swap_state == SW_IDLE) |=> $stable(stream_select) || swap_start)
    else $error("select moved outside a swap");

  // the select flips at the edge where the steer count has run out, and only there
  AST_STEER_FLIP: assert property (@(posedge clk) disable iff (!reset_n)
    (steer_pending && steer_cnt == 5'h00) |=> stream_select != $past(stream_select))
    else $error("select did not flip at steer count end");

  AST_STEER_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_steer && lane0) |=> stream_steer_delay == $past(w_data[7:0]))
    else $error("steer delay write lost");

  AST_OVERLAP_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_overlap && lane0) |=> dual_sample_overlap_delay == $past(w_data[7:0]))
    else $error("overlap delay write lost");

  COV_STEER_ZERO: cover property (@(posedge clk) disable iff (!reset_n)
    swap_start && stream_steer_delay[DLY_MSB:0] == 5'h00);
  COV_SWAP: cover property (@(posedge clk) disable iff (!reset_n) swap_start);
  COV_TOGGLE: cover property (@(posedge clk) disable iff (!reset_n) $changed(stream_select));
  COV_SLVERR: cover property (@(posedge clk) disable iff (!reset_n)
    s_axi_bvalid && s_axi_bresp == RESP_SLVERR);

endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the trim and swap-delay register bank
`timescale 1ns/10ps
`default_nettype none
module testbench
  import trim_swap_pkg::*;
;
  logic        clk, reset_n;
  logic [7:0]  fuse_c, fuse_d;
  logic [31:0] awaddr, wdata, araddr;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  trim_c, trim_d, ovl, steer;
  logic        cal_en, dual, sel;
  logic        dual_q   = 1'b0;
  logic        sel_q    = 1'b0;
  int          num_errors, checks, swap_mark, tog_mark;
  int          cnt      = 0;
  int          sc       = 0;
  int          last_len = -1;
  int          last_sel = -1;
  int          n_swap   = 0;
  int          n_tog    = 0;
  int          ov_tab[3] = '{0, 7, 31};
  int          st_tab[3] = '{31, 0, 7};

  trim_swap_regs i_dut (
    .clk(clk), .reset_n(reset_n), .fuse_trim_c(fuse_c), .fuse_trim_d(fuse_d),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .input_c_termination_trim(trim_c), .input_d_termination_trim(trim_d),
    .dual_sample_overlap_delay(ovl), .stream_steer_delay(steer),
    .calibration_enable(cal_en), .dual_sample_active(dual), .stream_select(sel));

  // ----------------------------------------
  // clock, swap monitor, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // counts are taken on values from before each edge, so a level set at edge E shows from E+1;
  // a flip of the select never coincides with a rise of the overlap, hence sc + 1
  always @(posedge clk) begin
    dual_q <= dual;
    sel_q  <= sel;
    if (dual === 1'b1 && dual_q !== 1'b1) begin
      sc     <= 0;
      n_swap <= n_swap + 1;
    end else begin
      sc <= sc + 1;
    end
    if (dual === 1'b1) begin
      cnt <= cnt + 1;
    end else if (dual_q === 1'b1) begin
      last_len <= cnt;
      cnt      <= 0;
    end
    if (sel !== sel_q) begin
      last_sel <= sc + 1;
      n_tog    <= n_tog + 1;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors = num_errors + 1;
    final_report;
  end

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %0t data got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %0t response got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    checks = checks + 1;
    if (got != exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %0t cycle count got %0d expected %0d", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] adr(input logic [9:0] idx);
    return {20'h00000, idx, 2'b00};
  endfunction

  task automatic reg_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    check_resp(bresp, er);
    bready <= 1'b0;
  endtask

  task automatic reg_read(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    check_data(rdata, ed);
    check_resp(rresp, er);
    rready <= 1'b0;
  endtask

  task automatic final_report;
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    fuse_c = 8'hA5;
    fuse_d = 8'h3C;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {num_errors, checks} = '0;
    repeat (5) @(posedge clk);
    check_data({24'h000000, ovl}, 32'h00000008);
    check_data({24'h000000, steer}, 32'h00000007);
    reset_n <= 1'b1;
    reg_read(adr(IDX_TRIM_C), 32'h000000A5, RESP_OKAY);
    reg_read(adr(IDX_TRIM_D), 32'h0000003C, RESP_OKAY);
    reg_read(adr(IDX_OVERLAP), 32'h00000008, RESP_OKAY);
    reg_read(adr(IDX_STEER), 32'h00000007, RESP_OKAY);
    // trims are adjustable after the fuse load, both ends of the byte
    reg_write(adr(IDX_TRIM_C), 32'h000000FF, RESP_OKAY);
    reg_write(adr(IDX_TRIM_D), 32'h00000000, RESP_OKAY);
    reg_read(adr(IDX_TRIM_C), 32'h000000FF, RESP_OKAY);
    reg_read(adr(IDX_TRIM_D), 32'h00000000, RESP_OKAY);
    check_data({16'h0000, trim_c, trim_d}, 32'h0000FF00);
    // without the low byte lane a write changes nothing but is still answered
    wstrb <= 4'h0;
    reg_write(adr(IDX_TRIM_C), 32'h00000012, RESP_OKAY);
    wstrb <= 4'hF;
    reg_read(adr(IDX_TRIM_C), 32'h000000FF, RESP_OKAY);
    reg_write(32'h00000300, 32'h00000055, RESP_SLVERR);
    reg_read(32'h00000300, 32'h00000000, RESP_SLVERR);
    // swaps at boundary delays; overlap only changed with calibration off
    for (int i = 0; i < 3; i++) begin
      reg_write(adr(IDX_CONTROL), 32'h00000000, RESP_OKAY);
      reg_write(adr(IDX_OVERLAP), 32'(ov_tab[i]), RESP_OKAY);
      reg_write(adr(IDX_STEER), 32'(st_tab[i]), RESP_OKAY);
      reg_read(adr(IDX_OVERLAP), 32'(ov_tab[i]), RESP_OKAY);
      check_data({24'h000000, steer}, 32'(st_tab[i]));
      reg_write(adr(IDX_CONTROL), 32'h00000003, RESP_OKAY);
      repeat (80) @(posedge clk);
      check_data({31'h00000000, cal_en}, 32'h00000001);
      check_count(last_len, 4 + 2 * ov_tab[i]);
      check_count(last_sel, 1 + st_tab[i]);
    end
    // three swaps leave the select flipped and the sequencer idle
    reg_read(adr(IDX_STATUS), 32'h0000000C, RESP_OKAY);
    reg_read(adr(IDX_CONTROL), 32'h00000001, RESP_OKAY);
    // a swap request without calibration enable starts nothing
    swap_mark = n_swap;
    tog_mark = n_tog;
    reg_write(adr(IDX_CONTROL), 32'h00000002, RESP_OKAY);
    repeat (80) @(posedge clk);
    check_count(n_swap, swap_mark);
    check_count(n_tog, tog_mark);
    final_report;
  end
endmodule
`default_nettype wire
